// ==== charger_regs_defs.vh ====
// Register map, field positions, reset values and timing figures of the charger register bank.
`ifndef CHARGER_REGS_DEFS_VH
`define CHARGER_REGS_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_AUTO_CHARGE_CONTROL  8'h17
`define ADDR_LATCHED_FAULT_FLAGS  8'h18
`define ADDR_CHARGER_CYCLE_STATUS 8'h19

// ----------------------------------------------------------------------------
// Auto-charge control fields
// ----------------------------------------------------------------------------
`define AUTO_EN_BIT      7
`define IRQ_EN_BIT       6
`define RECHG_MSB        5
`define RECHG_LSB        2
`define TMR_MSB          1
`define TMR_LSB          0
`define AUTO_EN_RESET    1'h0
`define IRQ_EN_RESET     1'h0
`define TMR_RESET        2'h1

// Recharge offset default code per cell count strap (00 = 2 cells .. 11 = 5 cells).
`define RECHG_DEF_2S     4'h3
`define RECHG_DEF_3S     4'h5
`define RECHG_DEF_4S     4'h7
`define RECHG_DEF_5S     4'h9
`define CELLS_2S         2'h0
`define CELLS_3S         2'h1
`define CELLS_4S         2'h2

// Recharge threshold in millivolts: offset plus step per code.
`define RECHG_OFFSET_MV  10'h032
`define RECHG_STEP_MV    10'h032

// Safety timer limit in hours per code.
`define TMR_CODE_5H      2'h0
`define TMR_CODE_8H      2'h1
`define TMR_CODE_12H     2'h2
`define TMR_HOURS_5      5'h05
`define TMR_HOURS_8      5'h08
`define TMR_HOURS_12     5'h0C
`define TMR_HOURS_24     5'h18

// ----------------------------------------------------------------------------
// Fault flag positions
// ----------------------------------------------------------------------------
`define FLT_BATOV_BIT    7
`define FLT_OC_BIT       5
`define FLT_RAIL_BIT     3

// ----------------------------------------------------------------------------
// Charger status fields
// ----------------------------------------------------------------------------
`define STAT_STATE_MSB   7
`define STAT_STATE_LSB   5
`define STAT_TMR_BIT     4
`define STAT_THERM_BIT   3
`define STAT_MODE_MSB    2
`define STAT_MODE_LSB    0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    40
`define IRQ_PULSE_NS     256000

`endif

// ==== charger_autocharge_fault_regs.v ====
// Auto-charge control, latched fault flags and charge status registers of the charger.
`timescale 1ns/1ps
`include "charger_regs_defs.vh"

// How it works
// - Auto recharge and termination allowed only while auto-charge enable bit is set.
// - With interrupt enable clear, state changes never pull charge-ok pin low.
// - Recharge offset code gives 50mV plus 50mV per step; default follows cell count.
// - Safety timer code selects 5, 8, 12 or 24 hours; resets to 8 hours.
// - Overvoltage, overcurrent and rail faults latch and hold until host reads them.
// - A fault still present at host read keeps its flag set.
// - After one read, a flag clears by itself once its fault disappears.
// - Status bits 7-5 report the charge cycle state code.
// - Status bit 4 reports safety timer expired.
// - Status bit 3 reports thermal regulation active.
// - Status bits 2-0 report the mode pin setting.
module charger_autocharge_fault_regs #(
    parameter IRQ_PULSE_CYCLES = (`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter CNT_W            = 13
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    input  wire       reg_reset_cmd,
    input  wire [1:0] cell_count,
    input  wire       battery_overvoltage_in,
    input  wire       overcurrent_in,
    input  wire       regulator_rail_in,
    input  wire [2:0] charge_cycle_state_in,
    input  wire       safety_timer_expired_in,
    input  wire       thermal_regulation_in,
    input  wire [2:0] mode_pin,
    output reg  [7:0] reg_rdata,
    output reg        reg_rd_valid,
    output reg        auto_recharge_allowed,
    output reg        auto_terminate_allowed,
    output reg  [9:0] recharge_threshold_mv,
    output reg  [4:0] safety_timer_hours,
    output reg        charger_good_pin_out,
    output reg        charger_good_pin_oe
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Default recharge offset code for the strapped cell count.
    function [3:0] rechg_default;
        input [1:0] cells;
        begin
            case (cells)
                `CELLS_2S: rechg_default = `RECHG_DEF_2S;
                `CELLS_3S: rechg_default = `RECHG_DEF_3S;
                `CELLS_4S: rechg_default = `RECHG_DEF_4S;
                default:   rechg_default = `RECHG_DEF_5S;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    localparam SYNC_W = 13;

    wire [SYNC_W-1:0] raw_in;
    reg  [SYNC_W-1:0] sync1_reg;
    reg  [SYNC_W-1:0] sync2_reg;

    assign raw_in = {cell_count, battery_overvoltage_in, overcurrent_in, regulator_rail_in,
                     charge_cycle_state_in, safety_timer_expired_in, thermal_regulation_in,
                     mode_pin};

    // Pins from the analog side pass two flip-flops before any logic sees them.
    always @(posedge sys_clk) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
    end

    // Slices follow the packing order of raw_in, most significant first.
    wire [1:0] cells_s    = sync2_reg[12:11];
    wire [2:0] fault_s    = sync2_reg[10:8];
    wire [2:0] state_s    = sync2_reg[7:5];
    wire       tmr_exp_s  = sync2_reg[4];
    wire       therm_s    = sync2_reg[3];
    wire [2:0] mode_s     = sync2_reg[2:0];

    // ------------------------------------------------------------------------
    // Auto-charge control register
    // ------------------------------------------------------------------------
    reg       auto_en_reg;
    reg       irq_en_reg;
    reg [3:0] rechg_reg;
    reg [1:0] tmr_reg;

    wire soft_rst = rst | reg_reset_cmd;
    wire wr_ctrl  = reg_wr & (reg_addr == `ADDR_AUTO_CHARGE_CONTROL);

    // Writable fields; only this offset accepts writes.
    always @(posedge sys_clk) begin
        if (soft_rst) begin
            auto_en_reg <= `AUTO_EN_RESET;
            irq_en_reg  <= `IRQ_EN_RESET;
            rechg_reg   <= rechg_default(cells_s);
            tmr_reg     <= `TMR_RESET;
        end else if (wr_ctrl) begin
            auto_en_reg <= reg_wdata[`AUTO_EN_BIT];
            irq_en_reg  <= reg_wdata[`IRQ_EN_BIT];
            rechg_reg   <= reg_wdata[`RECHG_MSB:`RECHG_LSB];
            tmr_reg     <= reg_wdata[`TMR_MSB:`TMR_LSB];
        end
    end

    // Decoded control outputs for the charger core.
    always @(posedge sys_clk) begin
        if (rst) begin
            auto_recharge_allowed  <= 1'h0;
            auto_terminate_allowed <= 1'h0;
            recharge_threshold_mv  <= 10'h000;
            safety_timer_hours     <= 5'h00;
        end else begin
            auto_recharge_allowed  <= auto_en_reg;
            auto_terminate_allowed <= auto_en_reg;
            recharge_threshold_mv  <= `RECHG_OFFSET_MV
                                      + `RECHG_STEP_MV * {6'h00, rechg_reg};
            case (tmr_reg)
                `TMR_CODE_5H:  safety_timer_hours <= `TMR_HOURS_5;
                `TMR_CODE_8H:  safety_timer_hours <= `TMR_HOURS_8;
                `TMR_CODE_12H: safety_timer_hours <= `TMR_HOURS_12;
                default:       safety_timer_hours <= `TMR_HOURS_24;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Latched fault flags
    // ------------------------------------------------------------------------
    reg  [2:0] flag_reg;
    reg  [2:0] seen_reg;
    wire       rd_fault = reg_rd & (reg_addr == `ADDR_LATCHED_FAULT_FLAGS);

    // A live fault sets its flag unless a reset or register-reset is active, so it wins over read self-clearing.
    // A read arms self-clear; the flag drops once the fault is gone.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : flt
            always @(posedge sys_clk) begin
                if (soft_rst) begin
                    flag_reg[g] <= 1'h0;
                    seen_reg[g] <= 1'h0;
                end else if (fault_s[g]) begin
                    flag_reg[g] <= 1'h1;
                    seen_reg[g] <= seen_reg[g] | (rd_fault & flag_reg[g]);
                end else if (seen_reg[g]) begin
                    flag_reg[g] <= 1'h0;
                    seen_reg[g] <= 1'h0;
                end else if (rd_fault & flag_reg[g]) begin
                    seen_reg[g] <= 1'h1;
                end
            end
        end
    endgenerate

    // Fault register image; reserved bits stay zero.
    wire [7:0] fault_image;
    assign fault_image = ({7'h00, flag_reg[2]} << `FLT_BATOV_BIT)
                       | ({7'h00, flag_reg[1]} << `FLT_OC_BIT)
                       | ({7'h00, flag_reg[0]} << `FLT_RAIL_BIT);

    // ------------------------------------------------------------------------
    // Charger status register
    // ------------------------------------------------------------------------
    reg [2:0] state_reg;
    reg       tmr_exp_reg;
    reg       therm_reg;
    reg [2:0] mode_reg;

    // Status snapshots; a register-reset clears them for one cycle.
    always @(posedge sys_clk) begin
        if (soft_rst) begin
            state_reg   <= 3'h0;
            tmr_exp_reg <= 1'h0;
            therm_reg   <= 1'h0;
            mode_reg    <= 3'h0;
        end else begin
            state_reg   <= state_s;
            tmr_exp_reg <= tmr_exp_s;
            therm_reg   <= therm_s;
            mode_reg    <= mode_s;
        end
    end

    wire [7:0] status_image;
    assign status_image = {state_reg, tmr_exp_reg, therm_reg, mode_reg};

    // ------------------------------------------------------------------------
    // Charge-ok interrupt pulse
    // ------------------------------------------------------------------------
    reg [2:0]       state_prev_reg;
    reg [CNT_W-1:0] pulse_cnt_reg;
    wire            state_changed = (state_prev_reg != state_s);

    // Each state change with interrupt enable set reloads the low pulse; the pin is open drain, so
    // it is only ever driven low and released otherwise.
    always @(posedge sys_clk) begin
        if (rst) begin
            state_prev_reg       <= 3'h0;
            pulse_cnt_reg        <= {CNT_W{1'b0}};
            charger_good_pin_out <= 1'h0;
            charger_good_pin_oe  <= 1'h0;
        end else begin
            state_prev_reg       <= state_s;
            charger_good_pin_out <= 1'h0;
            if (state_changed && irq_en_reg) begin
                pulse_cnt_reg       <= IRQ_PULSE_CYCLES[CNT_W-1:0];
                charger_good_pin_oe <= 1'h1;
            end else if (pulse_cnt_reg > {{(CNT_W-1){1'b0}}, 1'b1}) begin
                pulse_cnt_reg       <= pulse_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                charger_good_pin_oe <= 1'h1;
            end else begin
                pulse_cnt_reg       <= {CNT_W{1'b0}};
                charger_good_pin_oe <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------

    // Read data appears one cycle after the strobe; unmapped offsets read zero.
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'h0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_AUTO_CHARGE_CONTROL:  reg_rdata <= {auto_en_reg, irq_en_reg,
                                                              rechg_reg, tmr_reg};
                    `ADDR_LATCHED_FAULT_FLAGS:  reg_rdata <= fault_image;
                    `ADDR_CHARGER_CYCLE_STATUS: reg_rdata <= status_image;
                    default:                    reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// ==== charger_host_model.sv ====
// Host processor model that reads and writes the charger registers over the strobe port.
`timescale 1ns/1ps
module charger_host_model (
    input  logic       sys_clk,
    input  logic [7:0] reg_rdata,
    input  logic       reg_rd_valid,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic [7:0] reg_wdata,
    output logic       reg_rd
);
    // Idle bus at time zero with both strobes low.
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
    // One write, held over one sampling edge; released lines show the inverse value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge sys_clk) #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    // One read; the answer is taken at the edge that shows the valid pulse.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        int n;
        @(posedge sys_clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge sys_clk) #1 {reg_addr, reg_rd} = {~a, 1'b0};
        for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) @(posedge sys_clk) #1;
        if (reg_rd_valid !== 1'b1) charger_autocharge_fault_regs_bench.complete_run(1'b1);
        q = reg_rdata;
    endtask
endmodule

// ==== charger_autocharge_fault_regs_chk.sv ====
// Port-level assertions of the charger register bank.
`timescale 1ns/1ps
module charger_autocharge_fault_regs_chk #(
    parameter IRQ_PULSE_CYCLES = 6400
) (
    input logic       sys_clk,
    input logic       rst,
    input logic [7:0] reg_addr,
    input logic       reg_wr,
    input logic [7:0] reg_wdata,
    input logic       reg_rd,
    input logic       reg_reset_cmd,
    input logic       battery_overvoltage_in,
    input logic [7:0] reg_rdata,
    input logic       auto_recharge_allowed,
    input logic       auto_terminate_allowed,
    input logic [9:0] recharge_threshold_mv,
    input logic [4:0] safety_timer_hours,
    input logic       charger_good_pin_oe
);
    logic [7:0]  ov_cnt;
    logic [15:0] pls_cnt;
    logic [4:0]  hrs;
    logic        wr17;
    // Hours decoded from write data, and a plain host write to the control register.
    assign hrs  = reg_wdata[1] ? (reg_wdata[0] ? 5'h18 : 5'h0C) : (reg_wdata[0] ? 5'h08 : 5'h05);
    assign wr17 = reg_wr && reg_addr == 8'h17 && !reg_reset_cmd;
    // Cycles of present overvoltage and of the pin pulse.
    always @(posedge sys_clk) begin
        ov_cnt  <= (rst || reg_reset_cmd || !battery_overvoltage_in) ? 8'h00 : ov_cnt + 8'h01;
        pls_cnt <= (rst || !charger_good_pin_oe) ? 16'h0000 : pls_cnt + 16'h0001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_WR_AUTO: assert property (wr17 |-> ##2 auto_recharge_allowed == $past(reg_wdata[7], 2))
        else $error("auto enable output wrong after write");
    AST_AUTO_PAIR: assert property (auto_recharge_allowed == auto_terminate_allowed)
        else $error("recharge and terminate enables differ");
    AST_RECHG: assert property (wr17 |-> ##2 recharge_threshold_mv == 10'h032 +
        10'h032 * $past(reg_wdata[5:2], 2)) else $error("recharge threshold wrong");
    AST_TMR: assert property (wr17 |-> ##2 safety_timer_hours == $past(hrs, 2))
        else $error("safety timer hours wrong");
    AST_CMD_RESET: assert property (reg_reset_cmd |-> ##2 safety_timer_hours == 5'h08
        && !auto_recharge_allowed) else $error("register reset left control fields");
    AST_RSVD: assert property (reg_rd && reg_addr == 8'h18 |=> (reg_rdata & 8'h57) == 8'h00)
        else $error("reserved fault bits not zero");
    AST_FLT_KEEP: assert property (reg_rd && reg_addr == 8'h18 && ov_cnt > 8'h03
        |=> reg_rdata[7]) else $error("present overvoltage not flagged");
    AST_PULSE: assert property ($fell(charger_good_pin_oe) |-> pls_cnt >= IRQ_PULSE_CYCLES)
        else $error("charge ok pulse too short");
endmodule
bind charger_autocharge_fault_regs charger_autocharge_fault_regs_chk #(
    .IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)
) chk_inst (
    .sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_reset_cmd,
    .battery_overvoltage_in, .reg_rdata, .auto_recharge_allowed, .auto_terminate_allowed,
    .recharge_threshold_mv, .safety_timer_hours, .charger_good_pin_oe
);

// ==== charger_autocharge_fault_regs_bench.sv ====
// Self-checking bench of the charger register bank against a behavioural register model.
`timescale 1ns/1ps
module charger_autocharge_fault_regs_bench;
    localparam int PULSE = 20;
    logic       sys_clk, rst, reg_wr, reg_rd, reg_reset_cmd, reg_rd_valid;
    logic       battery_overvoltage_in, overcurrent_in, regulator_rail_in;
    logic       safety_timer_expired_in, thermal_regulation_in;
    logic       auto_recharge_allowed, auto_terminate_allowed;
    logic       charger_good_pin_out, charger_good_pin_oe;
    logic [1:0] cell_count;
    logic [2:0] charge_cycle_state_in, mode_pin;
    logic [4:0] safety_timer_hours;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [9:0] recharge_threshold_mv;
    int         n_fail = 0;
    int         n_compared = 0;
    int         ctrl;
    int         hrs_tab [4] = '{5, 8, 12, 24};
    charger_autocharge_fault_regs #(.IRQ_PULSE_CYCLES(PULSE)) charger_autocharge_fault_regs_inst (
        .sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_reset_cmd, .cell_count,
        .battery_overvoltage_in, .overcurrent_in, .regulator_rail_in, .charge_cycle_state_in,
        .safety_timer_expired_in, .thermal_regulation_in, .mode_pin, .reg_rdata, .reg_rd_valid,
        .auto_recharge_allowed, .auto_terminate_allowed, .recharge_threshold_mv,
        .safety_timer_hours, .charger_good_pin_out, .charger_good_pin_oe
    );
    charger_host_model charger_host_model_inst (
        .sys_clk, .reg_rdata, .reg_rd_valid, .reg_addr, .reg_wr, .reg_wdata, .reg_rd
    );
    // Waits n rising edges and steps just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk) #1;
    endtask
    // Compares one value and counts it.
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run(input bit timed_out);
        if (timed_out) n_fail++;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Reads one register and compares it with the model.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        charger_host_model_inst.rd(a, q);
        chk(q, e);
    endtask
    // Control register and its decoded outputs against the model value.
    task automatic check_ctrl();
        rdchk(8'h17, 8'(ctrl));
        chk(auto_recharge_allowed, ctrl[7]);
        chk(auto_terminate_allowed, ctrl[7]);
        chk(recharge_threshold_mv, 50 + 50 * ctrl[5:2]);
        chk(safety_timer_hours, hrs_tab[ctrl[1:0]]);
    endtask
    // Measures the next pulse on the charge-ok pin after a state change.
    task automatic pulse_len(input int e);
        int n;
        int w;
        n = 0;
        for (w = 0; w < 8 && charger_good_pin_oe !== 1'b1; w++) tick(1);
        while (charger_good_pin_oe === 1'b1 && n < 3 * PULSE) begin
            n++;
            tick(1);
        end
        chk(n, e);
        chk(charger_good_pin_out, 1'b0);
    endtask
    // Free-running 25 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Reset, control writes, status changes, faults and the register-reset command.
    initial begin
        void'($urandom(48626));
        {rst, reg_reset_cmd, battery_overvoltage_in, overcurrent_in, regulator_rail_in} = 5'h10;
        {safety_timer_expired_in, thermal_regulation_in, charge_cycle_state_in, mode_pin} = 8'h00;
        cell_count = 2'($urandom);
        tick(16);
        rst = 1'b0;
        ctrl = 1 + (3 + 2 * cell_count) * 4;
        tick(2);
        check_ctrl();
        rdchk(8'h18, 8'h00);
        rdchk(8'h19, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ctrl = ($urandom & 'h80) + i * 20 + i;
            charger_host_model_inst.wr(8'h17, 8'(ctrl));
            check_ctrl();
        end
        charger_host_model_inst.wr(8'h18, 8'hFF);
        rdchk(8'h18, 8'h00);
        ctrl = ctrl | 'h40;
        charger_host_model_inst.wr(8'h17, 8'(ctrl));
        for (int s = 1; s < 9; s++) begin
            if (s == 8) charger_host_model_inst.wr(8'h17, 8'(ctrl & 'hBF));
            {safety_timer_expired_in, thermal_regulation_in, mode_pin} = 5'($urandom);
            charge_cycle_state_in = 3'(s);
            pulse_len(s < 8 ? PULSE : 0);
            rdchk(8'h19, {charge_cycle_state_in, safety_timer_expired_in,
                thermal_regulation_in, mode_pin});
        end
        {battery_overvoltage_in, overcurrent_in, regulator_rail_in} = 3'h7;
        tick(4);
        {battery_overvoltage_in, overcurrent_in, regulator_rail_in} = 3'h0;
        tick(4);
        rdchk(8'h18, 8'hA8);
        rdchk(8'h18, 8'h00);
        battery_overvoltage_in = 1'b1;
        tick(5);
        rdchk(8'h18, 8'h80);
        rdchk(8'h18, 8'h80);
        battery_overvoltage_in = 1'b0;
        tick(5);
        rdchk(8'h18, 8'h00);
        overcurrent_in = 1'b1;
        charger_host_model_inst.wr(8'h17, 8'hFF);
        tick(3);
        overcurrent_in = 1'b0;
        tick(3);
        reg_reset_cmd = 1'b1;
        tick(1);
        reg_reset_cmd = 1'b0;
        ctrl = 1 + (3 + 2 * cell_count) * 4;
        check_ctrl();
        rdchk(8'h18, 8'h00);
        complete_run(1'b0);
    end
endmodule
